// File: csep_pkg.sv
`default_nettype none
package csep_pkg;

  localparam int DATA_W = 256;
  localparam int BYTES = 32;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W = 2;

  // Byte lane where a straddled second packet starts
  localparam int SPLIT_LANE = 16;

  // Interface width selection codes
  localparam logic [1:0] WIDTH_64 = 2'h0;
  localparam logic [1:0] WIDTH_128 = 2'h1;
  localparam logic [1:0] WIDTH_256 = 2'h2;

  // Active byte lanes per width, then the low and high halves of a split beat
  localparam logic [31:0] LANES_64 = 32'h0000_00FF;
  localparam logic [31:0] LANES_128 = 32'h0000_FFFF;
  localparam logic [31:0] LANES_256 = 32'hFFFF_FFFF;
  localparam logic [31:0] LANES_LOW_HALF = 32'h0000_FFFF;
  localparam logic [31:0] LANES_HIGH_HALF = 32'hFFFF_0000;

  // Second packet ends in dword 6 or 7 only
  localparam logic [1:0] SEC_OFS_HIGH = 2'h3;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic PTR_RST = 1'h0;
  localparam logic ERR_RST = 1'h0;

  typedef enum logic [1:0] {
    ST_PASS = 2'b01,
    ST_SPLIT = 2'b10
  } csep_state_e;

  // Beat offered by the completion source inside the core
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] byte_en;
    logic first_start;
    logic second_start;
    logic [3:0] first_end;
    logic [3:0] second_end;
    logic has_payload;
    logic payload_err;
  } csep_src_beat_s;

  // Sideband, packed MSB first so bit positions follow the stream layout
  typedef struct packed {
    logic [BYTES-1:0] parity;
    logic discontinue;
    logic [3:0] second_end_flags;
    logic [3:0] first_end_flags;
    logic second_start_flag;
    logic first_start_flag;
    logic [BYTES-1:0] byte_en;
  } csep_sideband_s;

  localparam int SB_W = $bits(csep_sideband_s);

  typedef struct packed {
    logic [DATA_W-1:0] data;
    csep_sideband_s sb;
  } csep_out_beat_s;

endpackage : csep_pkg
`default_nettype wire

// File: csep_top.sv
// Function
// - Second-end field is zero unless the bus is 256 bits with straddling enabled.
// - Second-end bit 0 marks a second packet end; bits 3:1 give last dword.
// - Second packet last-dword offset is reported only as 6 or 7.
// - Second end always comes with first end and second start in that beat.
// - Abort flag raised in final beat when payload fetch hit an uncorrectable error.
// - Abort flag never raised for a packet without payload.
// - Abort flag only in last payload beat, where first end bit is high.
// - No second packet starts in a beat carrying the abort flag.
// - In endpoint mode the payload error is also reported for error reporting.
// - Parity bit i is odd parity over data byte i.
// - Unused upper parity bits are zero on 128-bit and 64-bit buses.
// - Beat moves on valid and ready both high; held steady while ready low.
// - Second packet starts only at lane 16, after first ended in lanes 0-15; the core checks only that the first has ended in that beat.
// - First-end bit 0 marks first packet end; bits 3:1 give last dword when straddling, else zero.
`default_nettype none
module csep_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] WIDTH_SEL_IN,
  input wire logic STRADDLE_EN_IN,
  input wire logic ENDPOINT_MODE_IN,
  input wire logic SRC_VALID_IN,
  output logic SRC_READY_OUT,
  input wire csep_pkg::csep_src_beat_s SRC_BEAT_IN,
  output logic COMPLETION_VALID_OUT,
  input wire logic COMPLETION_READY_IN,
  output logic [csep_pkg::DATA_W-1:0] COMPLETION_DATA_BUS_OUT,
  output csep_pkg::csep_sideband_s COMPLETION_SIDEBAND_OUT,
  output logic PAYLOAD_ERR_REPORT_OUT
);

  function automatic logic [31:0] lane_mask(input logic [1:0] width_sel);
    logic [31:0] m;
    m = csep_pkg::LANES_256;
    case (width_sel)
      csep_pkg::WIDTH_64: m = csep_pkg::LANES_64;
      csep_pkg::WIDTH_128: m = csep_pkg::LANES_128;
      default: m = csep_pkg::LANES_256;
    endcase
    return m;
  endfunction : lane_mask

  function automatic logic [31:0] odd_parity(input logic [csep_pkg::DATA_W-1:0] d);
    logic [31:0] p;
    p = 32'h0000_0000;
    for (int i = 0; i < csep_pkg::BYTES; i++) begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction : odd_parity

  csep_pkg::csep_state_e state_r;
  csep_pkg::csep_state_e state_nxt;
  csep_pkg::csep_out_beat_s mem_r [csep_pkg::BUF_DEPTH];
  logic [csep_pkg::CNT_W-1:0] count_r;
  logic [csep_pkg::CNT_W-1:0] count_nxt;
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic err_report_r;
  logic wr_ptr_nxt;
  logic rd_ptr_nxt;
  logic err_report_nxt;

  wire logic [31:0] width_mask;
  wire logic straddle_on;
  wire logic first_ends;
  wire logic disc;
  wire logic second_ok;
  wire logic second_ends;
  wire logic need_split;
  wire logic in_split;
  wire logic [3:0] second_end_fmt;
  wire logic [31:0] be_masked;
  wire logic [31:0] parity_masked;
  wire logic buf_space;
  wire logic buf_wr;
  wire logic buf_rd;
  wire logic buf_empty;
  wire logic buf_full;
  wire logic split_enter;
  wire logic split_leave;
  wire logic err_event;
  wire logic [3:0] first_end_fmt;
  wire logic pass_second_start;
  wire logic [3:0] pass_second_end;
  wire logic [31:0] pass_byte_en;
  wire logic [31:0] split_byte_en;
  wire csep_pkg::csep_out_beat_s head_beat;
  csep_pkg::csep_sideband_s sb_pass;
  csep_pkg::csep_sideband_s sb_split;
  csep_pkg::csep_out_beat_s beat_wr;

  assign width_mask = lane_mask(WIDTH_SEL_IN);
  assign straddle_on = (WIDTH_SEL_IN == csep_pkg::WIDTH_256) & STRADDLE_EN_IN;
  assign first_ends = SRC_BEAT_IN.first_end[0];
  // Abort only on the last beat of a packet that carries payload
  assign disc = SRC_BEAT_IN.payload_err & SRC_BEAT_IN.has_payload & first_ends;
  // Second start only at lane 16 once the first packet has ended
  assign second_ok = straddle_on & SRC_BEAT_IN.second_start & first_ends;
  assign second_ends = second_ok & SRC_BEAT_IN.second_end[0];
  // Lanes 24-31 sit in dword 6 or 7, so only the low offset bit survives
  assign second_end_fmt = second_ends ? {csep_pkg::SEC_OFS_HIGH, SRC_BEAT_IN.second_end[1], 1'b1} : 4'h0;
  // An aborted beat that also opens a second packet is issued as two beats
  assign need_split = disc & second_ok;
  assign in_split = (state_r == csep_pkg::ST_SPLIT);
  assign be_masked = SRC_BEAT_IN.byte_en & width_mask;
  assign parity_masked = odd_parity(SRC_BEAT_IN.data) & width_mask;
  // Without straddling the offset bits mean nothing, so only the end bit is kept
  assign first_end_fmt = straddle_on ? SRC_BEAT_IN.first_end : {3'h0, first_ends};
  // A split holds the second packet's lanes and flags back for the follow-up beat
  assign pass_second_start = need_split ? 1'b0 : second_ok;
  assign pass_second_end = need_split ? 4'h0 : second_end_fmt;
  assign pass_byte_en = need_split ? (be_masked & csep_pkg::LANES_LOW_HALF) : be_masked;
  assign split_byte_en = be_masked & csep_pkg::LANES_HIGH_HALF;

  // First (or only) beat
  always_comb begin
    sb_pass.parity = parity_masked;
    sb_pass.discontinue = disc;
    sb_pass.first_end_flags = first_end_fmt;
    sb_pass.first_start_flag = SRC_BEAT_IN.first_start;
    sb_pass.second_start_flag = pass_second_start;
    sb_pass.second_end_flags = pass_second_end;
    sb_pass.byte_en = pass_byte_en;
  end

  // Follow-up beat: the held-back second packet, still at lane 16
  always_comb begin
    sb_split.parity = parity_masked;
    sb_split.discontinue = 1'b0;
    sb_split.first_end_flags = second_end_fmt;
    sb_split.first_start_flag = 1'b1;
    sb_split.second_start_flag = 1'b0;
    sb_split.second_end_flags = 4'h0;
    sb_split.byte_en = split_byte_en;
  end

  always_comb begin
    beat_wr.data = SRC_BEAT_IN.data;
    beat_wr.sb = in_split ? sb_split : sb_pass;
  end

  // Honest full: the buffer only takes a beat while it has a free entry
  assign buf_empty = (count_r == csep_pkg::CNT_RST);
  assign buf_full = (count_r == csep_pkg::BUF_DEPTH[csep_pkg::CNT_W-1:0]);
  assign buf_space = ~buf_full;
  assign buf_wr = SRC_VALID_IN & buf_space;
  assign buf_rd = COMPLETION_VALID_OUT & COMPLETION_READY_IN;
  assign wr_ptr_nxt = buf_wr ? ~wr_ptr_r : wr_ptr_r;
  assign rd_ptr_nxt = buf_rd ? ~rd_ptr_r : rd_ptr_r;
  assign split_enter = buf_wr & need_split;
  assign split_leave = buf_wr;
  // Source is held during the first half of a split beat
  assign SRC_READY_OUT = buf_space & (in_split | ~need_split);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      csep_pkg::ST_PASS: begin
        if (split_enter) begin
          state_nxt = csep_pkg::ST_SPLIT;
        end
      end
      csep_pkg::ST_SPLIT: begin
        if (split_leave) begin
          state_nxt = csep_pkg::ST_PASS;
        end
      end
      default: state_nxt = csep_pkg::ST_PASS;
    endcase
  end

  always_comb begin
    count_nxt = count_r;
    case ({buf_wr, buf_rd})
      2'b10: count_nxt = count_r + 2'h1;
      2'b01: count_nxt = count_r - 2'h1;
      default: count_nxt = count_r;
    endcase
  end

  // One short process per register keeps every reset path easy to audit
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= csep_pkg::ST_PASS;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      count_r <= csep_pkg::CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_ptr_r <= csep_pkg::PTR_RST;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_ptr_r <= csep_pkg::PTR_RST;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Entries only change on write, so a stalled head stays steady
  always_ff @(posedge CORE_CLK_IN) begin
    if (buf_wr) begin
      mem_r[wr_ptr_r] <= beat_wr;
    end
  end

  // One-cycle error report as the aborted beat enters the buffer
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      err_report_r <= csep_pkg::ERR_RST;
    end else begin
      err_report_r <= err_report_nxt;
    end
  end

  assign err_event = buf_wr & beat_wr.sb.discontinue;
  assign err_report_nxt = err_event & ENDPOINT_MODE_IN;

  // Idle outputs read as zero so a stale entry is never mistaken for a beat
  assign head_beat = mem_r[rd_ptr_r];
  assign COMPLETION_VALID_OUT = ~buf_empty;
  assign COMPLETION_DATA_BUS_OUT = COMPLETION_VALID_OUT ? head_beat.data : '0;
  assign COMPLETION_SIDEBAND_OUT = COMPLETION_VALID_OUT ? head_beat.sb : '0;
  assign PAYLOAD_ERR_REPORT_OUT = err_report_r;

endmodule : csep_top
`default_nettype wire

// File: csep_top_assertions.sv
`default_nettype none
module csep_top_assertions (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] WIDTH_SEL_IN,
  input wire logic STRADDLE_EN_IN,
  input wire logic ENDPOINT_MODE_IN,
  input wire logic SRC_VALID_IN,
  input wire logic COMPLETION_VALID_OUT,
  input wire logic COMPLETION_READY_IN,
  input wire logic [csep_pkg::DATA_W-1:0] COMPLETION_DATA_BUS_OUT,
  input wire csep_pkg::csep_sideband_s COMPLETION_SIDEBAND_OUT,
  input wire logic PAYLOAD_ERR_REPORT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  csep_pkg::csep_sideband_s sb;
  logic v;
  logic [31:0] odd;
  assign sb = COMPLETION_SIDEBAND_OUT;
  assign v = COMPLETION_VALID_OUT;
  always_comb for (int i = 0; i < 32; i++) odd[i] = ~^COMPLETION_DATA_BUS_OUT[8*i+:8];
  a_hold_on_stall: assert property (v && !COMPLETION_READY_IN |=> v && $stable(COMPLETION_DATA_BUS_OUT))
    else $error("beat changed while stalled");
  a_second_end_cfg: assert property (v && !(WIDTH_SEL_IN == 2'h2 && STRADDLE_EN_IN) |-> !sb.second_end_flags)
    else $error("second end set without straddle");
  a_second_end_ofs: assert property (v && sb.second_end_flags[0] |-> sb.second_end_flags[3:2] == 2'h3)
    else $error("second end offset not 6 or 7");
  a_second_end_pair: assert property (v && sb.second_end_flags[0] |-> sb.first_end_flags[0] && sb.second_start_flag)
    else $error("second end without companions");
  a_abort_last_beat: assert property (v && sb.discontinue |-> sb.first_end_flags[0] && !sb.second_start_flag)
    else $error("abort outside last beat");
  a_parity_full: assert property (v && WIDTH_SEL_IN == 2'h2 |-> sb.parity == odd)
    else $error("parity wrong");
  a_parity_narrow: assert property (v && WIDTH_SEL_IN == 2'h0 |-> sb.parity == (odd & 32'h0000_00FF))
    else $error("narrow parity wrong");
  a_report_cause: assert property (PAYLOAD_ERR_REPORT_OUT |-> $past(ENDPOINT_MODE_IN) && $past(SRC_VALID_IN))
    else $error("report without cause");
  c_abort: cover property (v && sb.discontinue);
  c_second: cover property (v && sb.second_end_flags[0]);
  c_stall: cover property (v && !COMPLETION_READY_IN);
endmodule : csep_top_assertions
`default_nettype wire

// File: csep_sink_model.sv
`default_nettype none
module csep_sink_model (
  input wire logic clk_in,
  input wire logic [1:0] md_in,
  input wire logic v_in,
  input wire logic [csep_pkg::DATA_W-1:0] d_in,
  input wire csep_pkg::csep_sideband_s sb_in,
  output logic rdy_out,
  output logic [csep_pkg::DATA_W-1:0] d_out,
  output csep_pkg::csep_sideband_s sb_out,
  output int n_out,
  output int ok_out,
  output int bad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  bit tick_r;
  // Mode 0 ready, 1 every other cycle, 2 stalled
  assign rdy_out = md_in == 2'h0 || (md_in == 2'h1 && tick_r);
  always @(posedge clk_in) begin
    tick_r <= !tick_r;
    if (v_in && rdy_out) begin
      n_out <= n_out + 1;
      sb_out <= sb_in;
      d_out <= d_in;
      // Aborted beat is counted as bad, never as a completed packet
      if (sb_in.discontinue) bad_out <= bad_out + 1;
      else if (sb_in.first_end_flags[0]) ok_out <= ok_out + 1;
    end
  end
endmodule : csep_sink_model
`default_nettype wire

// File: csep_top_bench.sv
`default_nettype none
module csep_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] wsel = 2'h2;
  logic strad = 1'b0;
  logic ep = 1'b0;
  logic sv = 1'b0;
  logic [1:0] md = 2'h0;
  logic srdy, cv, crdy, rpt;
  logic [255:0] cd, ld;
  csep_pkg::csep_src_beat_s src = '0;
  csep_pkg::csep_sideband_s csb, last;
  int errors = 0, checked = 0, cyc = 0, pul = 0, n, ok, bad;
  csep_top dut (.CORE_CLK_IN(clk), .RST_IN(rst), .WIDTH_SEL_IN(wsel), .STRADDLE_EN_IN(strad),
    .ENDPOINT_MODE_IN(ep), .SRC_VALID_IN(sv), .SRC_READY_OUT(srdy), .SRC_BEAT_IN(src),
    .COMPLETION_VALID_OUT(cv), .COMPLETION_READY_IN(crdy), .COMPLETION_DATA_BUS_OUT(cd),
    .COMPLETION_SIDEBAND_OUT(csb), .PAYLOAD_ERR_REPORT_OUT(rpt));
  csep_sink_model sink (.clk_in(clk), .md_in(md), .v_in(cv), .d_in(cd), .sb_in(csb), .rdy_out(crdy),
    .d_out(ld), .sb_out(last), .n_out(n), .ok_out(ok), .bad_out(bad));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rpt === 1'b1) pul++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  function automatic csep_pkg::csep_src_beat_s mk(input logic [7:0] s, input logic [3:0] se, input logic pe);
    mk = '0;
    for (int i = 0; i < 32; i++) mk.data[8*i+:8] = s + 8'(i);
    mk.byte_en = 32'hFFFF_FFFF;
    mk.first_start = 1'b1;
    mk.first_end = 4'h7;
    mk.second_start = se[0];
    mk.second_end = se;
    mk.has_payload = s[0];
    mk.payload_err = pe;
  endfunction : mk
  function automatic logic [2:0] top_dword(input logic [31:0] be);
    top_dword = 3'h0;
    for (int i = 0; i < 32; i++) if (be[i]) top_dword = 3'(i / 4);
  endfunction : top_dword
  // Caller stands at a falling edge; returns at one with the beat taken
  task automatic send(input csep_pkg::csep_src_beat_s b);
    src = b;
    sv = 1'b1;
    // Let ready settle on the new beat before looking at it
    #1;
    while (srdy !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask : send
  task automatic drain();
    sv = 1'b0;
    repeat (2) @(negedge clk);
    while (cv !== 1'b0) @(negedge clk);
  endtask : drain
  task automatic t_width();
    logic [31:0] m;
    csep_pkg::csep_src_beat_s b;
    for (int w = 0; w < 3; w++) begin
      wsel = 2'(w);
      m = w == 0 ? 32'h0000_00FF : w == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      b = mk(8'h03 + 8'(w * 40), 4'h0, 1'b0);
      send(b);
      drain();
      for (int i = 0; i < 32; i++) check(last.parity[i], m[i] & ~^b.data[8*i+:8]);
      check(last.byte_en, m);
      check(ld[31:0], b.data[31:0]);
      check(ld[255:224], b.data[255:224]);
    end
  endtask : t_width
  task automatic t_straddle();
    logic [3:0] se;
    csep_pkg::csep_src_beat_s b;
    for (int k = 0; k < 4; k++) begin
      strad = k < 3;
      se = k == 0 ? 4'hD : k == 1 ? 4'hF : 4'h3;
      b = mk(8'h41, se, 1'b0);
      // Offset 6 case: the second packet's last byte is lane 27
      b.byte_en = k == 0 ? 32'h0FFF_FFFF : 32'hFFFF_FFFF;
      send(b);
      drain();
      if (k < 3) check(last.second_end_flags[3:1], top_dword(b.byte_en));
      check(last.second_end_flags, k == 3 ? 4'h0 : {2'h3, se[1], 1'b1});
      check({last.first_end_flags[0], last.second_start_flag}, {1'b1, k < 3});
    end
  endtask : t_straddle
  task automatic t_abort();
    int n0, b0, k0, p0;
    n0 = n;
    b0 = bad;
    k0 = ok;
    p0 = pul;
    ep = 1'b1;
    strad = 1'b1;
    send(mk(8'h55, 4'hD, 1'b1));
    send(mk(8'h66, 4'h0, 1'b1));
    drain();
    check(n - n0, 3);
    check(bad - b0, 1);
    check(ok - k0, 2);
    check(pul - p0, 1);
    ep = 1'b0;
    send(mk(8'h57, 4'h0, 1'b1));
    drain();
    check(pul - p0, 1);
    check(bad - b0, 2);
  endtask : t_abort
  task automatic t_stall();
    int n0;
    n0 = n;
    md = 2'h2;
    strad = 1'b0;
    for (int i = 0; i < 2; i++) send(mk(8'h71, 4'h0, 1'b0));
    sv = 1'b0;
    check(srdy, 1'b0);
    md = 2'h1;
    for (int i = 0; i < 3; i++) send(mk(8'h81 + 8'(i), 4'h0, 1'b0));
    drain();
    check(n - n0, 5);
  endtask : t_stall
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_width();
    t_straddle();
    t_abort();
    t_stall();
    final_report();
  end
endmodule : csep_top_bench
bind csep_top csep_top_assertions chk (.CORE_CLK_IN, .RST_IN, .WIDTH_SEL_IN, .STRADDLE_EN_IN, .ENDPOINT_MODE_IN,
  .SRC_VALID_IN, .COMPLETION_VALID_OUT, .COMPLETION_READY_IN, .COMPLETION_DATA_BUS_OUT, .COMPLETION_SIDEBAND_OUT,
  .PAYLOAD_ERR_REPORT_OUT);
`default_nettype wire
